// ---- src/sipo_latch_pkg.sv ----
// Functional notes
// - Shift register, storage register, eight outputs
// - Shift edge advances stages, input to zero
// - Storage edge copies stages to storage
// - Clear low empties shift stages
// - Clear leaves storage register untouched
// - Storage edge during clear loads zeros
// - Enable low drives storage onto outputs
// - Enable high floats all parallel outputs
// - Enable never alters register contents
// - Stage seven moves to cascade output
// - Storage edge alone keeps cascade output
// - Simultaneous edges store pre-shift contents
// - Cascade output feeds next serial input
package sipo_latch_pkg;
  localparam int WIDTH      = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int STAGE_SIX  = 6;
  localparam logic [WIDTH-1:0] SHIFT_RESET   = 8'h00;
  localparam logic [WIDTH-1:0] STORAGE_INIT  = 8'h00;
  localparam logic [2:0]       SYNC_RESET    = 3'h0;

  typedef struct packed {
    logic serial_in;
    logic shift_clock;
    logic storage_clock;
    logic shift_clear_n;
    logic output_enable_n;
  } pins_t;
endpackage

// ---- src/serial_in_parallel_out_latch.sv ----
`timescale 1ns/1ps
`default_nettype none
module sipo_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   count;
  } fifo_state_t;
  logic [WIDTH-1:0] mem [DEPTH];
  fifo_state_t      st_reg;
  fifo_state_t      st_next;
  logic             push;
  logic             pop;
  assign in_ready  = (st_reg.count != (AW+1)'(DEPTH));
  assign out_valid = (st_reg.count != '0);
  assign out_data  = mem[st_reg.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_comb begin
    st_next = st_reg;
    if (push) st_next.wr = st_reg.wr + 1'b1;
    if (pop) st_next.rd = st_reg.rd + 1'b1;
    st_next.count = st_reg.count + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clk) begin
    if (rst) st_reg <= '0;
    else st_reg <= st_next;
    if (push) mem[st_reg.wr] <= in_data;
  end
endmodule

module serial_in_parallel_out_latch
  import sipo_latch_pkg::*;
(
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             srst,
  // Controller pins
  input  wire logic             serial_in,
  input  wire logic             shift_clock,
  input  wire logic             storage_clock,
  input  wire logic             shift_clear_n,
  input  wire logic             output_enable_n,
  // Parallel outputs, three-state as value plus enable
  output logic      [WIDTH-1:0] parallel_out,
  output logic      [WIDTH-1:0] parallel_out_oe,
  // Cascade
  output logic                  serial_cascade_out
);
  typedef struct packed {
    pins_t             sync1;
    pins_t             sync2;
    logic              shift_clock_d;
    logic              storage_clock_d;
    logic [WIDTH-1:0]  shift_stage_bits;
    logic [WIDTH-1:0]  storage;
    logic [WIDTH-1:0]  out_val;
    logic [WIDTH-1:0]  out_oe;
    logic              cascade;
  } state_t;

  state_t           s_reg;
  state_t           s_next;
  pins_t            pins_raw;
  logic             shift_edge;
  logic             store_edge;
  logic             fifo_out_valid;
  logic [WIDTH-1:0] fifo_out_data;
  logic             snap_valid;

  assign pins_raw = '{serial_in, shift_clock, storage_clock, shift_clear_n, output_enable_n};
  assign shift_edge = s_reg.sync2.shift_clock && !s_reg.shift_clock_d;
  assign store_edge = s_reg.sync2.storage_clock && !s_reg.storage_clock_d;
  // Snapshot taken before the shift in the same cycle
  assign snap_valid = store_edge;

  // Snapshots queue in a FIFO whose drain is always ready; a full queue would drop a storage edge
  sipo_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (ref_clk),
    .rst       (srst),
    .in_valid  (snap_valid),
    .in_ready  (),
    .in_data   (s_reg.shift_stage_bits),
    .out_valid (fifo_out_valid),
    .out_ready (1'b1),
    .out_data  (fifo_out_data)
  );

  always_comb begin
    s_next = s_reg;
    s_next.sync1 = pins_raw;
    s_next.sync2 = s_reg.sync1;
    s_next.shift_clock_d = s_reg.sync2.shift_clock;
    s_next.storage_clock_d = s_reg.sync2.storage_clock;
    if (!s_reg.sync2.shift_clear_n) begin
      s_next.shift_stage_bits = SHIFT_RESET;
    end else if (shift_edge) begin
      s_next.shift_stage_bits = {s_reg.shift_stage_bits[WIDTH-2:0], s_reg.sync2.serial_in};
    end
    // Storage loads only from the queue, clear never touches it
    if (fifo_out_valid) begin
      s_next.storage = fifo_out_data;
    end
    // Cascade follows the top stage only, storage edge irrelevant
    s_next.cascade = s_next.shift_stage_bits[WIDTH-1];
    // Enable gates only the drivers, never the registers
    s_next.out_val = s_next.storage;
    s_next.out_oe = s_reg.sync2.output_enable_n ? '0 : '1;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_reg <= '0;
      s_reg.sync1.shift_clear_n <= 1'b1;
      s_reg.sync2.shift_clear_n <= 1'b1;
      s_reg.sync1.output_enable_n <= 1'b1;
      s_reg.sync2.output_enable_n <= 1'b1;
      s_reg.storage <= STORAGE_INIT;
      s_reg.out_val <= STORAGE_INIT;
    end else begin
      s_reg <= s_next;
    end
  end

  assign parallel_out       = s_reg.out_val;
  assign parallel_out_oe    = s_reg.out_oe;
  assign serial_cascade_out = s_reg.cascade;
endmodule
`default_nettype wire

// ---- verification/sipo_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module sipo_checker
  import sipo_latch_pkg::*;
(
  input wire logic ref_clk, srst, serial_in, shift_clock, storage_clock,
  input wire logic shift_clear_n, output_enable_n, serial_cascade_out,
  input wire logic [WIDTH-1:0] parallel_out, parallel_out_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Long quiet windows outlast the pin sync and FIFO delay
  AST_OE_OFF: assert property (output_enable_n [*6] |-> parallel_out_oe == 8'h00)
    else $error("oe off");
  AST_OE_ON: assert property ((!output_enable_n) [*6] |-> parallel_out_oe == 8'hff)
    else $error("oe on");
  AST_OE_ALL: assert property (parallel_out_oe inside {8'h00, 8'hff})
    else $error("oe split");
  AST_CLEAR: assert property ((!shift_clear_n) [*5] |-> !serial_cascade_out)
    else $error("clear");
  AST_PO_HOLD: assert property ((!storage_clock) [*8] |-> $stable(parallel_out))
    else $error("po moved");
  AST_CLR_HOLD: assert property ((!shift_clear_n && !storage_clock) [*8]
    |-> $stable(parallel_out)) else $error("po cleared");
  AST_SC_HOLD: assert property ((!shift_clock && shift_clear_n) [*8]
    |-> $stable(serial_cascade_out)) else $error("sc moved");
  AST_CLR_LOAD: assert property ((!shift_clear_n) [*4] ##1 $rose(storage_clock)
    |-> ##8 parallel_out == 8'h00) else $error("no zero load");
  cover property ($rose(serial_cascade_out));
  cover property ($fell(parallel_out_oe[0]));
  cover property ($rose(storage_clock) && !shift_clear_n);
endmodule
bind serial_in_parallel_out_latch sipo_checker i_sipo_checker (.*);
`default_nettype wire

// ---- verification/host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic ref_clk,
  output logic serial_in, shift_clock, storage_clock, shift_clear_n, output_enable_n
);
  initial {serial_in, shift_clock, storage_clock, shift_clear_n, output_enable_n} = 5'h02;
  // Each level held w cycles; one cycle is enough for the block to see the edge
  task automatic tick(input logic sh, st, int w);
    repeat (w) @(posedge ref_clk);
    {shift_clock, storage_clock} <= {sh, st};
    repeat (w) @(posedge ref_clk);
    {shift_clock, storage_clock} <= 2'h0;
  endtask
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [7:0] PAT = 8'hc3;
  logic ref_clk, srst, serial_in, shift_clock, storage_clock, shift_clear_n;
  logic output_enable_n, serial_cascade_out;
  logic [7:0] parallel_out, parallel_out_oe;
  int n_errors, total_checks, cycles;
  serial_in_parallel_out_latch i_serial_in_parallel_out_latch (.*);
  host_model i_host_model (.*);
  initial begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Scenarios need well under a thousand cycles
  always @(posedge ref_clk) if (++cycles == 3000) begin
    n_errors++;
    stop_test();
  end
  task automatic check(input string nm, input logic [7:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, got);
    end
  endtask
  task automatic settle();
    repeat (12) @(posedge ref_clk);
  endtask
  task automatic s_load();
    // Four cycles high, four low: a 400 ns link clock
    for (int i = 7; i >= 0; i--) begin
      i_host_model.serial_in <= PAT[i];
      i_host_model.tick(1'h1, 1'h0, 4);
    end
    settle();
    check("cascade", {7'h00, serial_cascade_out}, 8'h01);
    i_host_model.tick(1'h0, 1'h1, 4);
    settle();
    check("load", parallel_out, PAT);
    check("oe", parallel_out_oe, 8'hff);
  endtask
  task automatic s_tied();
    i_host_model.serial_in <= 1'h0;
    i_host_model.tick(1'h1, 1'h1, 5);
    settle();
    check("tied", parallel_out, PAT);
    i_host_model.tick(1'h0, 1'h1, 3);
    settle();
    check("store", parallel_out, 8'h86);
    check("casc", {7'h00, serial_cascade_out}, 8'h01);
  endtask
  task automatic s_oe();
    i_host_model.output_enable_n <= 1'h1;
    settle();
    check("off", parallel_out_oe, 8'h00);
    i_host_model.output_enable_n <= 1'h0;
    settle();
    check("kept", parallel_out, 8'h86);
  endtask
  task automatic s_clear();
    i_host_model.shift_clear_n <= 1'h0;
    settle();
    check("clr", {7'h00, serial_cascade_out}, 8'h00);
    check("held", parallel_out, 8'h86);
    i_host_model.tick(1'h0, 1'h1, 5);
    settle();
    check("empty", parallel_out, 8'h00);
    i_host_model.shift_clear_n <= 1'h1;
  endtask
  initial begin
    srst = 1'h1;
    repeat (6) @(posedge ref_clk);
    srst <= 1'h0;
    s_load();
    s_tied();
    s_oe();
    s_clear();
    stop_test();
  end
endmodule
`default_nettype wire
